// ===== verilog/exec_pkg.sv
// Behaviour
// (RULE1) opcode DF, 6 cycles: carry forced to one, other five flags kept
// (RULE2) opcode 31 immediate, 6 cycles: byte loaded into selector at FDh, flags kept
// (RULE3) selector high nibble picks sixteen-register group used as working registers 0-15
// (RULE4) selector low nibble picks expanded bank 0-F for working register accesses
// (RULE5) expanded bank with unimplemented working group resolves to bank zero
// (RULE6) nonzero bank keeps standard file reachable except addresses 00h-0Fh
// (RULE7) register operand with high nibble 1110b names working register from low nibble
// (RULE8) opcodes D0 register and D1 indirect, 6 cycles: shift right one place
// (RULE9) shift: old bit 0 into carry, bit 7 kept and copied to bit 6
// (RULE10) shift: zero and sign from result, overflow cleared, decimal and half kept
// (RULE11) opcode 6F stops system clock and oscillator, flags kept
// (RULE12) stopped state left only by reset, then execution restarts at 000Ch
// (RULE13) program places no-operation FF just before the stop opcode
// (RULE14) subtract opcodes 22,23 take 6 cycles; 24 to 27 take 10 cycles
// (RULE15) subtract adds two's complement of source to destination; source untouched
// (RULE16) subtract: carry cleared on carry out of bit 7, else set for borrow
// (RULE17) subtract: half cleared on carry out of bit 3, else set; decimal set
// (RULE18) subtract: overflow when signs differ and result sign equals source sign
// (RULE19) subtract: zero only for zero result, sign only for negative result
// (RULE20) write-back and flags take effect together at the last instruction cycle
package exec_pkg;

  localparam logic [7:0] OPC_SCF      = 8'hDF;
  localparam logic [7:0] OPC_SRP      = 8'h31;
  localparam logic [7:0] OPC_SRA_R    = 8'hD0;
  localparam logic [7:0] OPC_SRA_IR   = 8'hD1;
  localparam logic [7:0] OPC_STOP     = 8'h6F;
  localparam logic [7:0] OPC_SUB_RR   = 8'h22;
  localparam logic [7:0] OPC_SUB_RIR  = 8'h23;
  localparam logic [7:0] OPC_SUB_GG   = 8'h24;
  localparam logic [7:0] OPC_SUB_GIG  = 8'h25;
  localparam logic [7:0] OPC_SUB_GIM  = 8'h26;
  localparam logic [7:0] OPC_SUB_IGIM = 8'h27;

  localparam logic [3:0] CYC_SHORT = 4'h6;
  localparam logic [3:0] CYC_LONG  = 4'hA;
  localparam logic [3:0] CYC_ONE   = 4'h1;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  localparam logic [7:0]  SELECT_ADDR    = 8'hFD;
  localparam logic [7:0]  SELECT_RESET   = 8'h00;
  localparam logic [15:0] RESTART_VECTOR = 16'h000C;
  localparam logic [3:0]  WORK_PREFIX    = 4'hE;
  localparam logic [3:0]  EXP_GROUP      = 4'h0;
  localparam logic [3:0]  BANK_STD       = 4'h0;
  localparam logic [3:0]  NIBBLE_ZERO    = 4'h0;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_S = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_D = 4;
  localparam int unsigned FLAG_H = 5;
  localparam logic [5:0]  FLAGS_RESET = 6'h00;

  localparam logic [2:0] STEP_SRC  = 3'h0;
  localparam logic [2:0] STEP_DST  = 3'h1;
  localparam logic [2:0] STEP_SPTR = 3'h2;
  localparam logic [2:0] STEP_DPTR = 3'h3;
  localparam logic [2:0] STEP_DVAL = 3'h4;
  localparam logic [2:0] STEP_DONE = 3'h5;
  localparam logic [2:0] STEP_INC  = 3'h1;

  typedef enum logic [1:0] {
    ALU_NONE = 2'h0,
    ALU_SCF  = 2'h1,
    ALU_SRA  = 2'h2,
    ALU_SUB  = 2'h3
  } alu_op_t;

  typedef enum logic [3:0] {
    ST_WAKE = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_EXEC = 4'b0100,
    ST_STOP = 4'b1000
  } exec_state_t;

endpackage

// ===== verilog/exec_alu.sv
module exec_alu (
  // operation and operands
  input  wire exec_pkg::alu_op_t alu_op_in,
  input  wire logic [7:0]        dst_in,
  input  wire logic [7:0]        src_in,
  input  wire logic [5:0]        flags_in,
  // outcome
  output logic [7:0]             result_out,
  output logic [5:0]             flags_out,
  output logic                   write_dst_out
);

  logic [8:0] sum_full;
  logic [4:0] sum_low;

  // two's complement add keeps the source operand read-only
  assign sum_full = {1'b0, dst_in} + {1'b0, ~src_in} + 9'h001;   // [RULE15]
  assign sum_low  = {1'b0, dst_in[3:0]} + {1'b0, ~src_in[3:0]} + 5'h01;

  always_comb
  begin
    result_out    = dst_in;
    flags_out     = flags_in;
    write_dst_out = 1'b0;
    case (alu_op_in)
      exec_pkg::ALU_SCF:
      begin
        flags_out[exec_pkg::FLAG_C] = 1'b1;   // [RULE1]
      end
      exec_pkg::ALU_SRA:
      begin
        result_out                  = {dst_in[7], dst_in[7:1]};   // [RULE8] [RULE9]
        write_dst_out               = 1'b1;
        flags_out[exec_pkg::FLAG_C] = dst_in[0];   // [RULE9]
        flags_out[exec_pkg::FLAG_Z] = ({dst_in[7], dst_in[7:1]} == exec_pkg::BYTE_ZERO);   // [RULE10]
        flags_out[exec_pkg::FLAG_S] = dst_in[7];   // [RULE10]
        flags_out[exec_pkg::FLAG_V] = 1'b0;   // [RULE10]
      end
      exec_pkg::ALU_SUB:
      begin
        result_out                  = sum_full[7:0];
        write_dst_out               = 1'b1;
        flags_out[exec_pkg::FLAG_C] = ~sum_full[8];   // [RULE16]
        flags_out[exec_pkg::FLAG_H] = ~sum_low[4];   // [RULE17]
        flags_out[exec_pkg::FLAG_D] = 1'b1;   // [RULE17]
        flags_out[exec_pkg::FLAG_V] = (dst_in[7] ^ src_in[7]) & (sum_full[7] == src_in[7]);   // [RULE18]
        flags_out[exec_pkg::FLAG_Z] = (sum_full[7:0] == exec_pkg::BYTE_ZERO);   // [RULE19]
        flags_out[exec_pkg::FLAG_S] = sum_full[7];   // [RULE19]
      end
      default:
      begin
        result_out = dst_in;
      end
    endcase
  end

endmodule

// ===== verilog/exec_addr_map.sv
module exec_addr_map (
  // operand byte to resolve
  input  wire logic [7:0] raw_in,
  input  wire logic       work_in,
  input  wire logic       plain_in,
  input  wire logic [7:0] select_in,
  // resolved location
  output logic [7:0]      addr_out,
  output logic [3:0]      bank_out
);

  logic is_work;

  // pointer contents are full addresses and never take the working shortcut
  assign is_work  = ~plain_in & (work_in | (raw_in[7:4] == exec_pkg::WORK_PREFIX));   // [RULE7]
  assign addr_out = is_work ? {select_in[7:4], raw_in[3:0]} : raw_in;   // [RULE3]

  // only the lowest sixteen addresses live in expanded banks; any other
  // group, working or direct, falls back to the standard file
  assign bank_out = ((addr_out[7:4] == exec_pkg::EXP_GROUP) && (select_in[3:0] != exec_pkg::BANK_STD))
                    ? select_in[3:0] : exec_pkg::BANK_STD;   // [RULE4] [RULE5] [RULE6]

endmodule

// ===== verilog/cpu_carry_pointer_shift_sub_exec.sv
module cpu_carry_pointer_shift_sub_exec (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // instruction stream
  input  wire logic        instr_valid_in,
  input  wire logic [7:0]  instr_opcode_in,
  input  wire logic [7:0]  instr_byte1_in,
  input  wire logic [7:0]  instr_byte2_in,
  output logic             instr_ready_out,
  output logic             instr_done_out,
  // register file read port, data expected in the same cycle as the address
  output logic [7:0]       rf_rd_addr_out,
  output logic [3:0]       rf_rd_bank_out,
  input  wire logic [7:0]  rf_rd_data_in,
  // register file write port
  output logic             rf_wr_en_out,
  output logic [7:0]       rf_wr_addr_out,
  output logic [3:0]       rf_wr_bank_out,
  output logic [7:0]       rf_wr_data_out,
  // processor state
  output logic [5:0]       flags_out,
  output logic [7:0]       select_out,
  // power and restart
  output logic             sclk_enable_out,
  output logic             osc_enable_out,
  output logic             restart_out,
  output logic [15:0]      restart_addr_out
);

  localparam logic [3:0] CNT_ONE_C = exec_pkg::CNT_ONE;

  exec_pkg::exec_state_t state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [2:0]  step_reg, step_next;
  logic        done_reg, done_next;

  exec_pkg::alu_op_t alu_op_reg, alu_op_next;
  logic        is_srp_reg, is_srp_next;
  logic        is_stop_reg, is_stop_next;
  logic [7:0]  src_raw_reg, src_raw_next;
  logic        src_work_reg, src_work_next;
  logic        src_ind_reg, src_ind_next;
  logic        src_imm_reg, src_imm_next;
  logic [7:0]  dst_raw_reg, dst_raw_next;
  logic        dst_work_reg, dst_work_next;
  logic        dst_ind_reg, dst_ind_next;

  logic [7:0]  rd_addr_reg, rd_addr_next;
  logic [3:0]  rd_bank_reg, rd_bank_next;
  logic        rd_sel_reg, rd_sel_next;
  logic [7:0]  tmp_src_reg, tmp_src_next;
  logic [7:0]  tmp_dst_reg, tmp_dst_next;
  logic [7:0]  src_val_reg, src_val_next;
  logic [7:0]  dst_val_reg, dst_val_next;
  logic [7:0]  dst_addr_reg, dst_addr_next;
  logic [3:0]  dst_bank_reg, dst_bank_next;
  logic        dst_sel_reg, dst_sel_next;

  logic [7:0]  select_reg, select_next;
  logic [5:0]  flags_reg, flags_next;
  logic        wr_en_reg, wr_en_next;
  logic [7:0]  wr_addr_reg, wr_addr_next;
  logic [3:0]  wr_bank_reg, wr_bank_next;
  logic [7:0]  wr_data_reg, wr_data_next;

  logic [7:0]  map_raw;
  logic        map_work;
  logic        map_plain;
  logic [7:0]  map_addr;
  logic [3:0]  map_bank;
  logic        map_is_sel;
  logic [7:0]  rd_value;
  logic [7:0]  alu_result;
  logic [5:0]  alu_flags;
  logic        alu_write;

  exec_addr_map u_map (
    .raw_in    (map_raw),
    .work_in   (map_work),
    .plain_in  (map_plain),
    .select_in (select_reg),
    .addr_out  (map_addr),
    .bank_out  (map_bank)
  );

  exec_alu u_alu (
    .alu_op_in     (alu_op_reg),
    .dst_in        (dst_val_reg),
    .src_in        (src_val_reg),
    .flags_in      (flags_reg),
    .result_out    (alu_result),
    .flags_out     (alu_flags),
    .write_dst_out (alu_write)
  );

  // the selector lives here, so reads of its address bypass the file
  assign rd_value   = rd_sel_reg ? select_reg : rf_rd_data_in;   // [RULE2]
  assign map_is_sel = (map_addr == exec_pkg::SELECT_ADDR) && (map_bank == exec_pkg::BANK_STD);

  always_comb
  begin
    map_raw   = src_raw_reg;
    map_work  = src_work_reg;
    map_plain = 1'b0;
    case (step_reg)
      exec_pkg::STEP_DST:
      begin
        map_raw  = dst_raw_reg;
        map_work = dst_work_reg;
      end
      exec_pkg::STEP_SPTR:
      begin
        map_raw   = tmp_src_reg;
        map_work  = 1'b0;
        map_plain = 1'b1;
      end
      exec_pkg::STEP_DPTR:
      begin
        map_raw   = tmp_dst_reg;
        map_work  = 1'b0;
        map_plain = 1'b1;
      end
      default:
      begin
        map_raw = src_raw_reg;
      end
    endcase
  end

  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    step_next     = step_reg;
    done_next     = 1'b0;
    alu_op_next   = alu_op_reg;
    is_srp_next   = is_srp_reg;
    is_stop_next  = is_stop_reg;
    src_raw_next  = src_raw_reg;
    src_work_next = src_work_reg;
    src_ind_next  = src_ind_reg;
    src_imm_next  = src_imm_reg;
    dst_raw_next  = dst_raw_reg;
    dst_work_next = dst_work_reg;
    dst_ind_next  = dst_ind_reg;
    rd_addr_next  = rd_addr_reg;
    rd_bank_next  = rd_bank_reg;
    rd_sel_next   = rd_sel_reg;
    tmp_src_next  = tmp_src_reg;
    tmp_dst_next  = tmp_dst_reg;
    src_val_next  = src_val_reg;
    dst_val_next  = dst_val_reg;
    dst_addr_next = dst_addr_reg;
    dst_bank_next = dst_bank_reg;
    dst_sel_next  = dst_sel_reg;
    select_next   = select_reg;
    flags_next    = flags_reg;
    wr_en_next    = 1'b0;
    wr_addr_next  = wr_addr_reg;
    wr_bank_next  = wr_bank_reg;
    wr_data_next  = wr_data_reg;
    case (state_reg)
      exec_pkg::ST_WAKE:
      begin
        state_next = exec_pkg::ST_IDLE;   // [RULE12]
      end
      exec_pkg::ST_IDLE:
      begin
        if (instr_valid_in)
        begin
          state_next    = exec_pkg::ST_EXEC;
          step_next     = exec_pkg::STEP_SRC;
          alu_op_next   = exec_pkg::ALU_NONE;
          is_srp_next   = 1'b0;
          is_stop_next  = 1'b0;
          src_raw_next  = instr_byte1_in;
          src_work_next = 1'b0;
          src_ind_next  = 1'b0;
          src_imm_next  = 1'b0;
          dst_raw_next  = instr_byte1_in;
          dst_work_next = 1'b0;
          dst_ind_next  = 1'b0;
          // unknown opcodes retire after one cycle with no effect
          cnt_next      = exec_pkg::CYC_ONE - CNT_ONE_C;
          case (instr_opcode_in)
            exec_pkg::OPC_SCF:
            begin
              alu_op_next = exec_pkg::ALU_SCF;
              cnt_next    = exec_pkg::CYC_SHORT - CNT_ONE_C;   // [RULE1]
            end
            exec_pkg::OPC_SRP:
            begin
              is_srp_next = 1'b1;
              cnt_next    = exec_pkg::CYC_SHORT - CNT_ONE_C;   // [RULE2]
            end
            exec_pkg::OPC_SRA_R, exec_pkg::OPC_SRA_IR:
            begin
              alu_op_next  = exec_pkg::ALU_SRA;
              dst_ind_next = (instr_opcode_in == exec_pkg::OPC_SRA_IR);   // [RULE8]
              cnt_next     = exec_pkg::CYC_SHORT - CNT_ONE_C;   // [RULE8]
            end
            exec_pkg::OPC_STOP:
            begin
              // a one-cycle stop relies on the preceding no-operation
              // having drained the fetch pipeline
              is_stop_next = 1'b1;   // [RULE13]
            end
            exec_pkg::OPC_SUB_RR, exec_pkg::OPC_SUB_RIR:
            begin
              alu_op_next   = exec_pkg::ALU_SUB;
              dst_raw_next  = {exec_pkg::NIBBLE_ZERO, instr_byte1_in[7:4]};
              dst_work_next = 1'b1;
              src_raw_next  = {exec_pkg::NIBBLE_ZERO, instr_byte1_in[3:0]};
              src_work_next = 1'b1;
              src_ind_next  = (instr_opcode_in == exec_pkg::OPC_SUB_RIR);
              cnt_next      = exec_pkg::CYC_SHORT - CNT_ONE_C;   // [RULE14]
            end
            exec_pkg::OPC_SUB_GG, exec_pkg::OPC_SUB_GIG:
            begin
              alu_op_next  = exec_pkg::ALU_SUB;
              dst_raw_next = instr_byte2_in;
              src_ind_next = (instr_opcode_in == exec_pkg::OPC_SUB_GIG);
              cnt_next     = exec_pkg::CYC_LONG - CNT_ONE_C;   // [RULE14]
            end
            exec_pkg::OPC_SUB_GIM, exec_pkg::OPC_SUB_IGIM:
            begin
              alu_op_next  = exec_pkg::ALU_SUB;
              src_raw_next = instr_byte2_in;
              src_imm_next = 1'b1;
              dst_ind_next = (instr_opcode_in == exec_pkg::OPC_SUB_IGIM);
              cnt_next     = exec_pkg::CYC_LONG - CNT_ONE_C;   // [RULE14]
            end
            default:
            begin
              alu_op_next = exec_pkg::ALU_NONE;
            end
          endcase
        end
      end
      exec_pkg::ST_EXEC:
      begin
        if (step_reg != exec_pkg::STEP_DONE)
        begin
          step_next = step_reg + exec_pkg::STEP_INC;
        end
        if (step_reg <= exec_pkg::STEP_DPTR)
        begin
          rd_addr_next = map_addr;
          rd_bank_next = map_bank;
          rd_sel_next  = map_is_sel;
        end
        case (step_reg)
          exec_pkg::STEP_SRC:
          begin
            rd_addr_next = map_addr;
          end
          exec_pkg::STEP_DST:
          begin
            tmp_src_next  = rd_value;
            dst_addr_next = map_addr;
            dst_bank_next = map_bank;
            dst_sel_next  = map_is_sel;
          end
          exec_pkg::STEP_SPTR:
          begin
            tmp_dst_next = rd_value;
          end
          exec_pkg::STEP_DPTR:
          begin
            // source is an immediate, the pointed byte, or the direct byte
            src_val_next = src_imm_reg ? src_raw_reg : (src_ind_reg ? rd_value : tmp_src_reg);
            if (dst_ind_reg)
            begin
              dst_addr_next = map_addr;
              dst_bank_next = map_bank;
              dst_sel_next  = map_is_sel;
            end
          end
          exec_pkg::STEP_DVAL:
          begin
            dst_val_next = dst_ind_reg ? rd_value : tmp_dst_reg;
          end
          default:
          begin
            step_next = exec_pkg::STEP_DONE;
          end
        endcase
        if (cnt_reg == exec_pkg::CNT_ZERO)
        begin
          done_next  = 1'b1;
          flags_next = alu_flags;   // [RULE20]
          state_next = is_stop_reg ? exec_pkg::ST_STOP : exec_pkg::ST_IDLE;   // [RULE11]
          if (is_srp_reg)
          begin
            select_next = src_raw_reg;   // [RULE2]
          end
          else if (alu_write && dst_sel_reg)
          begin
            select_next = alu_result;   // [RULE20]
          end
          else if (alu_write)
          begin
            wr_en_next   = 1'b1;   // [RULE20]
            wr_addr_next = dst_addr_reg;
            wr_bank_next = dst_bank_reg;
            wr_data_next = alu_result;
          end
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE_C;
        end
      end
      exec_pkg::ST_STOP:
      begin
        state_next = exec_pkg::ST_STOP;   // [RULE12]
      end
      default:
      begin
        state_next = exec_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg    <= exec_pkg::ST_WAKE;   // [RULE12]
      cnt_reg      <= exec_pkg::CNT_ZERO;
      step_reg     <= exec_pkg::STEP_SRC;
      done_reg     <= 1'b0;
      alu_op_reg   <= exec_pkg::ALU_NONE;
      is_srp_reg   <= 1'b0;
      is_stop_reg  <= 1'b0;
      src_raw_reg  <= exec_pkg::BYTE_ZERO;
      src_work_reg <= 1'b0;
      src_ind_reg  <= 1'b0;
      src_imm_reg  <= 1'b0;
      dst_raw_reg  <= exec_pkg::BYTE_ZERO;
      dst_work_reg <= 1'b0;
      dst_ind_reg  <= 1'b0;
      rd_addr_reg  <= exec_pkg::BYTE_ZERO;
      rd_bank_reg  <= exec_pkg::BANK_STD;
      rd_sel_reg   <= 1'b0;
      tmp_src_reg  <= exec_pkg::BYTE_ZERO;
      tmp_dst_reg  <= exec_pkg::BYTE_ZERO;
      src_val_reg  <= exec_pkg::BYTE_ZERO;
      dst_val_reg  <= exec_pkg::BYTE_ZERO;
      dst_addr_reg <= exec_pkg::BYTE_ZERO;
      dst_bank_reg <= exec_pkg::BANK_STD;
      dst_sel_reg  <= 1'b0;
      select_reg   <= exec_pkg::SELECT_RESET;
      flags_reg    <= exec_pkg::FLAGS_RESET;
      wr_en_reg    <= 1'b0;
      wr_addr_reg  <= exec_pkg::BYTE_ZERO;
      wr_bank_reg  <= exec_pkg::BANK_STD;
      wr_data_reg  <= exec_pkg::BYTE_ZERO;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      step_reg     <= step_next;
      done_reg     <= done_next;
      alu_op_reg   <= alu_op_next;
      is_srp_reg   <= is_srp_next;
      is_stop_reg  <= is_stop_next;
      src_raw_reg  <= src_raw_next;
      src_work_reg <= src_work_next;
      src_ind_reg  <= src_ind_next;
      src_imm_reg  <= src_imm_next;
      dst_raw_reg  <= dst_raw_next;
      dst_work_reg <= dst_work_next;
      dst_ind_reg  <= dst_ind_next;
      rd_addr_reg  <= rd_addr_next;
      rd_bank_reg  <= rd_bank_next;
      rd_sel_reg   <= rd_sel_next;
      tmp_src_reg  <= tmp_src_next;
      tmp_dst_reg  <= tmp_dst_next;
      src_val_reg  <= src_val_next;
      dst_val_reg  <= dst_val_next;
      dst_addr_reg <= dst_addr_next;
      dst_bank_reg <= dst_bank_next;
      dst_sel_reg  <= dst_sel_next;
      select_reg   <= select_next;
      flags_reg    <= flags_next;
      wr_en_reg    <= wr_en_next;
      wr_addr_reg  <= wr_addr_next;
      wr_bank_reg  <= wr_bank_next;
      wr_data_reg  <= wr_data_next;
    end
  end

  assign instr_ready_out  = (state_reg == exec_pkg::ST_IDLE);
  assign instr_done_out   = done_reg;
  assign rf_rd_addr_out   = rd_addr_reg;
  assign rf_rd_bank_out   = rd_bank_reg;
  assign rf_wr_en_out     = wr_en_reg;
  assign rf_wr_addr_out   = wr_addr_reg;
  assign rf_wr_bank_out   = wr_bank_reg;
  assign rf_wr_data_out   = wr_data_reg;
  assign flags_out        = flags_reg;
  assign select_out       = select_reg;
  // both gates drop together; only the asynchronous reset brings them back
  assign sclk_enable_out  = (state_reg != exec_pkg::ST_STOP);   // [RULE11]
  assign osc_enable_out   = (state_reg != exec_pkg::ST_STOP);   // [RULE11]
  assign restart_out      = (state_reg == exec_pkg::ST_WAKE);   // [RULE12]
  assign restart_addr_out = exec_pkg::RESTART_VECTOR;   // [RULE12]

endmodule

// ===== tb/exec_assertions.sv
module exec_chk (
  // watched ports
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic        instr_valid_in,
  input wire logic [7:0]  instr_opcode_in,
  input wire logic [7:0]  instr_byte1_in,
  input wire logic        instr_ready_out,
  input wire logic        instr_done_out,
  input wire logic        rf_wr_en_out,
  input wire logic [5:0]  flags_out,
  input wire logic [7:0]  select_out,
  input wire logic        sclk_enable_out,
  input wire logic        osc_enable_out,
  input wire logic        restart_out,
  input wire logic [15:0] restart_addr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic       tk = instr_valid_in && instr_ready_out;
  wire logic [7:0] op = instr_opcode_in;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_short;
    tk && op inside {8'hDF, 8'h31, 8'hD0, 8'hD1, 8'h22, 8'h23} |-> ##1 !instr_done_out[*6] ##1 instr_done_out;
  endproperty
  a_short: assert property (p_short) else $error("short op done timing");
  property p_long;
    tk && op inside {[8'h24:8'h27]} |-> ##3 !instr_done_out[*8] ##1 instr_done_out;
  endproperty
  a_long: assert property (p_long) else $error("long op done timing");
  property p_scf;
    tk && op == 8'hDF |-> ##7 flags_out == ($past(flags_out, 7) | 6'h01);
  endproperty
  a_scf: assert property (p_scf) else $error("carry force flags");
  property p_srp;
    tk && op == 8'h31 |-> ##7 select_out == $past(instr_byte1_in, 7) && flags_out == $past(flags_out, 7);
  endproperty
  a_srp: assert property (p_srp) else $error("selector load");
  property p_stop;
    tk && op == 8'h6F |-> ##2 !sclk_enable_out && !osc_enable_out && $stable(flags_out);
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry");
  property p_hold;
    !sclk_enable_out |=> !sclk_enable_out && !instr_ready_out && !rf_wr_en_out;
  endproperty
  a_hold: assert property (p_hold) else $error("left stop without reset");
  property p_restart;
    restart_out |-> restart_addr_out == 16'h000C ##1 !restart_out && instr_ready_out;
  endproperty
  a_restart: assert property (p_restart) else $error("restart vector");
  property p_wr;
    rf_wr_en_out |-> instr_done_out;
  endproperty
  a_wr: assert property (p_wr) else $error("write apart from done");
  property p_sub_d;
    tk && op inside {[8'h22:8'h27]} ##[7:11] instr_done_out |-> flags_out[4];
  endproperty
  a_sub_d: assert property (p_sub_d) else $error("subtract decimal flag");
  property p_sra;
    tk && op inside {8'hD0, 8'hD1} |-> ##7 !flags_out[3] && flags_out[5:4] == $past(flags_out[5:4], 7);
  endproperty
  a_sra: assert property (p_sra) else $error("shift flags");
  c_stop: cover property (tk && op == 8'h6F);
  c_long: cover property (tk && op == 8'h27);
  c_restart: cover property (restart_out);
endmodule

bind cpu_carry_pointer_shift_sub_exec exec_chk chk (.*);

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in, rst_b_in, instr_valid_in, instr_ready_out, instr_done_out, rf_wr_en_out;
  logic        sclk_enable_out, osc_enable_out, restart_out;
  logic [7:0]  instr_opcode_in, instr_byte1_in, instr_byte2_in, rf_rd_addr_out;
  logic [7:0]  rf_wr_addr_out, rf_wr_data_out, select_out;
  logic [3:0]  rf_rd_bank_out, rf_wr_bank_out;
  logic [5:0]  flags_out;
  logic [15:0] restart_addr_out;
  logic [7:0]  mem [0:4095];
  int          fails, n_compared;
  // file indexed by {bank, address}
  wire logic [7:0] rf_rd_data_in = mem[{rf_rd_bank_out, rf_rd_addr_out}];

  cpu_carry_pointer_shift_sub_exec dut (.*);

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
    if (rf_wr_en_out === 1'b1)
      mem[{rf_wr_bank_out, rf_wr_addr_out}] <= rf_wr_data_out;

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one instruction; ends a cycle after done so the file write has landed
  task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] cyc);
    int n;
    instr_opcode_in = op;
    instr_byte1_in = b1;
    instr_byte2_in = b2;
    instr_valid_in = 1'b1;
    @(posedge clk_in);
    #1;
    instr_valid_in = 1'b0;
    n = 0;
    while (instr_done_out !== 1'b1 && n < 12)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    chk(n[15:0], cyc); // cycle count
    if (n == 12)
      complete_run();
    @(posedge clk_in);
    #1;
  endtask

  initial
  begin
    fails = 0;
    n_compared = 0;
    rst_b_in = 1'b0;
    instr_valid_in = 1'b0;
    instr_opcode_in = 8'h00;
    instr_byte1_in = 8'h00;
    instr_byte2_in = 8'h00;
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'hA5 ^ i[7:0];
    repeat (5) @(posedge clk_in);
    #1;
    chk(select_out, 8'h00);
    rst_b_in = 1'b1;
    @(posedge clk_in);
    #1;
    run(8'h31, 8'h70, 8'h00, 6);
    chk(select_out, 8'h70);
    chk(flags_out, 6'h00);
    mem[12'h073] = 8'h16;
    mem[12'h07B] = 8'h20;
    run(8'h22, 8'h3B, 8'h00, 6);
    chk(mem[12'h073], 8'hF6);
    chk(mem[12'h07B], 8'h20);
    chk(flags_out, 6'h15);
    mem[12'h07F] = 8'h16;
    mem[12'h07A] = 8'h20;
    mem[12'h020] = 8'h11;
    run(8'h23, 8'hFA, 8'h00, 6);
    chk(mem[12'h07F], 8'h05);
    chk(flags_out, 6'h10);
    mem[12'h034] = 8'h2E;
    mem[12'h012] = 8'h1B;
    run(8'h24, 8'h12, 8'h34, 10);
    chk(mem[12'h034], 8'h13);
    mem[12'h073] = 8'h10;
    mem[12'h010] = 8'h01;
    mem[12'h04B] = 8'h82;
    run(8'h25, 8'hE3, 8'h4B, 10);
    chk(mem[12'h04B], 8'h81);
    mem[12'h0D4] = 8'h5F;
    mem[12'h05F] = 8'h4C;
    run(8'h27, 8'hD4, 8'h02, 10);
    chk(mem[12'h05F], 8'h4A);
    mem[12'h06C] = 8'h80;
    run(8'h26, 8'h6C, 8'h01, 10);
    chk(mem[12'h06C], 8'h7F);
    chk(flags_out, 6'h38);
    mem[12'h076] = 8'h31;
    run(8'hD0, 8'hE6, 8'h00, 6);
    chk(mem[12'h076], 8'h18);
    chk(flags_out, 6'h31);
    mem[12'h06D] = 8'h55;
    run(8'h26, 8'h6D, 8'h55, 10);
    chk(mem[12'h06D], 8'h00);
    chk(flags_out, 6'h12);
    run(8'hDF, 8'h00, 8'h00, 6);
    chk(flags_out, 6'h13);
    mem[12'h0C6] = 8'hDF;
    mem[12'h0DF] = 8'hB8;
    run(8'hD1, 8'hC6, 8'h00, 6);
    chk(mem[12'h0DF], 8'hDC);
    chk(flags_out, 6'h14);
    run(8'h31, 8'h7F, 8'h00, 6);
    mem[12'hF05] = 8'h09;
    run(8'h26, 8'h05, 8'h01, 10);
    chk(mem[12'hF05], 8'h08);
    chk(mem[12'h005], 8'hA0);
    mem[12'h071] = 8'h20;
    run(8'h26, 8'hE1, 8'h01, 10);
    chk(mem[12'h071], 8'h1F);
    run(8'hFF, 8'h00, 8'h00, 1);
    run(8'h6F, 8'h00, 8'h00, 1);
    chk({sclk_enable_out, osc_enable_out}, 2'b00);
    chk(flags_out, 6'h30);
    // an offered instruction must not wake the part
    instr_opcode_in = 8'hDF;
    instr_valid_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    chk({instr_ready_out, sclk_enable_out, flags_out}, 8'h30);
    rst_b_in = 1'b0;
    instr_valid_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk(restart_out, 1'b1);
    chk(restart_addr_out, 16'h000C);
    rst_b_in = 1'b1;
    @(posedge clk_in);
    #1;
    chk({sclk_enable_out, osc_enable_out, instr_ready_out}, 3'b111);
    complete_run();
  end
endmodule
